/* src/pfcs_cfg.svh */
// constants for the pin function configuration store
`ifndef PFCS_CFG_SVH
`define PFCS_CFG_SVH

`define PFCS_CMD_MULTI_PIN_CFG 8'hF9
`define PFCS_CMD_STORE_DEFAULT 8'h11
`define PFCS_CMD_STORE_USER 8'h15

`define PFCS_BIT_REMOTE_SRC 0
`define PFCS_BIT_RESERVED 1
`define PFCS_BIT_PG_EN 2
`define PFCS_BIT_EXT_REF 3
`define PFCS_BIT_TRACK 4
`define PFCS_BIT_PG_HIGHZ 5
`define PFCS_BIT_MODE_LO 6
`define PFCS_BIT_MODE_HI 7

`define PFCS_CFG_DEF_STANDALONE 8'h04
`define PFCS_CFG_DEF_LOADSHARE 8'h86
`define PFCS_OTHER_DEF 8'h00

`define PFCS_SET_WORDS 4
`define PFCS_IDX_W 2
`define PFCS_IDX_LAST 2'h3
`define PFCS_IDX_CFG 2'h0

`define PFCS_STORE_WAIT_MS 5
`define PFCS_CLK_HZ 20000000

`endif

/* src/pfcs_flash_store.sv */
// non-volatile settings sets: factory default and user area
`timescale 1ns/1ps
`include "pfcs_cfg.svh"
module pfcs_flash_store (
    input wire logic clk_i,
    input wire logic erase_n_i,
    input wire logic ce_i,
    input wire logic loadshare_i,
    input wire logic rd_user_i,
    input wire logic [`PFCS_IDX_W-1:0] rd_idx_i,
    output logic [7:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic [`PFCS_IDX_W-1:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic commit_i,
    output logic user_valid_o
);
    logic [7:0] user_mem_r [`PFCS_SET_WORDS];
    logic user_valid_r;

    // factory set, fixed, no write path
    function automatic logic [7:0] default_word(input logic [`PFCS_IDX_W-1:0] idx,
                                                input logic ls);
        if (idx == `PFCS_IDX_CFG) begin
            default_word = ls ? `PFCS_CFG_DEF_LOADSHARE : `PFCS_CFG_DEF_STANDALONE;
        end else begin
            default_word = `PFCS_OTHER_DEF;
        end
    endfunction

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            user_mem_r[wr_idx_i] <= wr_data_i;
        end
    end

    // user area empty until a store completes
    always_ff @(posedge clk_i or negedge erase_n_i) begin
        if (!erase_n_i) begin
            user_valid_r <= 1'b0;
        end else if (ce_i && commit_i) begin
            user_valid_r <= 1'b1;
        end
    end

    assign rd_data_o = rd_user_i ? user_mem_r[rd_idx_i] : default_word(rd_idx_i, loadshare_i);
    assign user_valid_o = user_valid_r;
endmodule

/* src/pfcs_pkg.sv */
// types of the pin function configuration store
package pfcs_pkg;
    typedef enum logic [1:0] {
        PFCS_ST_STRAP,
        PFCS_ST_LOAD,
        PFCS_ST_IDLE,
        PFCS_ST_STORE
    } pfcs_state_t;

    typedef logic [7:0] pfcs_byte_t;
endpackage

/* src/pfcs_top.sv */
// pin function configuration decoder and settings loader
// Notes on behaviour
// - bit 0 picks pin or bus on/off
// - pin pulled opposite its active level when bit 0 picks pin
// - bit 2 enables good output, bit 5 drive
// - variant fixes bits 7 and 1
// - factory word 0x04 or 0x86 by variant
// - host writes new word, functions follow
// - two sets, user set wins
// - boot loads default if user empty
// - store copies RAM to user area
// - store default command refused
// - word reached as command 0xF9
// - send byte acted on only with PEC
`timescale 1ns/1ps
`include "pfcs_cfg.svh"
module pfcs_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic flash_erase_n_i,
    input wire logic droop_load_share_variant_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_send_byte_i,
    input wire logic cmd_pec_ok_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic rsp_refused_o,
    output logic [7:0] rsp_data_o,
    input wire logic bus_on_i,
    input wire logic remote_pin_i,
    input wire logic remote_active_high_i,
    input wire logic power_good_i,
    output logic unit_on_o,
    output logic secondary_remote_on_off_source_o,
    output logic remote_pull_up_en_o,
    output logic remote_pull_down_en_o,
    output logic output_good_indicator_o,
    output logic output_good_indicator_oe_o,
    output logic [7:0] multi_pin_function_config_o,
    output logic boot_done_o,
    output logic user_set_loaded_o
);
    pfcs_pkg::pfcs_state_t state_r;
    logic [`PFCS_IDX_W-1:0] idx_r;
    logic [7:0] ram_r [`PFCS_SET_WORDS];
    logic loadshare_r;
    logic user_loaded_r;
    logic [7:0] flash_rd;
    logic user_valid;
    logic take;
    logic is_cfg_wr;
    logic is_cfg_rd;
    logic is_store_user;
    logic is_store_def;
    logic wr_ok;
    logic [7:0] cfg;

    // listed codes only: no tracking/ext ref, mode and reserved follow variant
    function automatic logic cfg_code_ok(input logic [7:0] c, input logic ls);
        logic mode_ok;
        mode_ok = ls ? (c[`PFCS_BIT_MODE_HI] && !c[`PFCS_BIT_MODE_LO] && c[`PFCS_BIT_RESERVED])
                     : (!c[`PFCS_BIT_MODE_HI] && !c[`PFCS_BIT_MODE_LO]
                        && !c[`PFCS_BIT_RESERVED]);
        cfg_code_ok = mode_ok && !c[`PFCS_BIT_TRACK] && !c[`PFCS_BIT_EXT_REF]
                      && !(c[`PFCS_BIT_PG_HIGHZ] && !c[`PFCS_BIT_PG_EN]);
    endfunction

    assign cfg = ram_r[`PFCS_IDX_CFG];
    assign cmd_ready_o = (state_r == pfcs_pkg::PFCS_ST_IDLE);
    assign take = ce_i && cmd_valid_i && cmd_ready_o;
    assign is_cfg_wr = cmd_write_i && !cmd_send_byte_i
                       && (cmd_code_i == `PFCS_CMD_MULTI_PIN_CFG);
    assign is_cfg_rd = !cmd_write_i && !cmd_send_byte_i
                       && (cmd_code_i == `PFCS_CMD_MULTI_PIN_CFG);
    assign is_store_user = cmd_send_byte_i && cmd_pec_ok_i
                           && (cmd_code_i == `PFCS_CMD_STORE_USER);
    assign is_store_def = cmd_send_byte_i && (cmd_code_i == `PFCS_CMD_STORE_DEFAULT);
    assign wr_ok = is_cfg_wr && cfg_code_ok(cmd_data_i, loadshare_r);

    pfcs_flash_store u_flash (
        .clk_i(clk_i),
        .erase_n_i(flash_erase_n_i),
        .ce_i(ce_i),
        .loadshare_i(loadshare_r),
        .rd_user_i(user_valid),
        .rd_idx_i(idx_r),
        .rd_data_o(flash_rd),
        .wr_en_i(state_r == pfcs_pkg::PFCS_ST_STORE),
        .wr_idx_i(idx_r),
        .wr_data_i(ram_r[idx_r]),
        .commit_i((state_r == pfcs_pkg::PFCS_ST_STORE) && (idx_r == `PFCS_IDX_LAST)),
        .user_valid_o(user_valid)
    );

    // sequencer: strap, boot load, idle, store
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= pfcs_pkg::PFCS_ST_STRAP;
            idx_r <= '0;
        end else if (ce_i) begin
            unique case (state_r)
                pfcs_pkg::PFCS_ST_STRAP: begin
                    state_r <= pfcs_pkg::PFCS_ST_LOAD;
                    idx_r <= '0;
                end
                pfcs_pkg::PFCS_ST_LOAD: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == `PFCS_IDX_LAST) begin
                        state_r <= pfcs_pkg::PFCS_ST_IDLE;
                    end
                end
                pfcs_pkg::PFCS_ST_IDLE: begin
                    idx_r <= '0;
                    if (take && is_store_user) begin
                        state_r <= pfcs_pkg::PFCS_ST_STORE;
                    end
                end
                pfcs_pkg::PFCS_ST_STORE: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == `PFCS_IDX_LAST) begin
                        state_r <= pfcs_pkg::PFCS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // variant strap caught after reset release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loadshare_r <= 1'b0;
        end else if (ce_i && state_r == pfcs_pkg::PFCS_ST_STRAP) begin
            loadshare_r <= droop_load_share_variant_i;
        end
    end

    // which set was loaded at boot
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            user_loaded_r <= 1'b0;
        end else if (ce_i && state_r == pfcs_pkg::PFCS_ST_STRAP) begin
            user_loaded_r <= user_valid;
        end
    end

    // working RAM: filled at boot, config word host-writable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `PFCS_SET_WORDS; i++) begin
                ram_r[i] <= 8'h00;
            end
        end else if (ce_i) begin
            if (state_r == pfcs_pkg::PFCS_ST_LOAD) begin
                ram_r[idx_r] <= flash_rd;
            end else if (take && wr_ok) begin
                ram_r[`PFCS_IDX_CFG] <= cmd_data_i;
            end
        end
    end

    // answer one cycle after a request is taken
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_refused_o <= 1'b0;
            rsp_data_o <= 8'h00;
        end else if (ce_i) begin
            rsp_valid_o <= take;
            if (take) begin
                rsp_refused_o <= !(wr_ok || is_cfg_rd || is_store_user);
                rsp_data_o <= is_cfg_rd ? cfg : 8'h00;
            end
        end
    end

    // functions selected by the live config word
    always_comb begin
        unit_on_o = cfg[`PFCS_BIT_REMOTE_SRC]
                    ? (remote_pin_i == remote_active_high_i) : bus_on_i;
        secondary_remote_on_off_source_o = cfg[`PFCS_BIT_REMOTE_SRC];
        remote_pull_up_en_o = cfg[`PFCS_BIT_REMOTE_SRC] && !remote_active_high_i;
        remote_pull_down_en_o = cfg[`PFCS_BIT_REMOTE_SRC] && remote_active_high_i;
        // active low indicator; high-z mode releases when good
        if (!cfg[`PFCS_BIT_PG_EN]) begin
            output_good_indicator_o = 1'b1;
            output_good_indicator_oe_o = 1'b0;
        end else if (cfg[`PFCS_BIT_PG_HIGHZ]) begin
            output_good_indicator_o = 1'b1;
            output_good_indicator_oe_o = !power_good_i;
        end else begin
            output_good_indicator_o = !power_good_i;
            output_good_indicator_oe_o = 1'b1;
        end
    end

    assign multi_pin_function_config_o = cfg;
    assign boot_done_o = (state_r == pfcs_pkg::PFCS_ST_IDLE)
                         || (state_r == pfcs_pkg::PFCS_ST_STORE);
    assign user_set_loaded_o = user_loaded_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_store_taken;
        take && is_store_user;
    endsequence
    sequence s_store_run;
        (state_r == pfcs_pkg::PFCS_ST_STORE)[*4];
    endsequence
    sequence s_boot_run;
        ce_i [*4];
    endsequence

    a_pin_source: assert property (
        cfg[0] && remote_pin_i == remote_active_high_i |-> unit_on_o)
        else $error("remote pin source not followed");
    a_pull_dir: assert property (
        cfg[0] |-> remote_pull_up_en_o != remote_pull_down_en_o
                   && remote_pull_down_en_o == remote_active_high_i)
        else $error("remote pull direction wrong");
    a_good_drive: assert property (
        cfg[2] && !cfg[5] |-> output_good_indicator_oe_o
                              && output_good_indicator_o == !power_good_i)
        else $error("push-pull indicator wrong");
    a_bad_code: assert property (
        take && is_cfg_wr && cmd_data_i[4] |=> rsp_refused_o && $stable(cfg))
        else $error("illegal config code accepted");
    a_factory_word: assert property (
        $rose(boot_done_o) && !user_loaded_r |->
            cfg == (loadshare_r ? 8'h86 : 8'h04))
        else $error("factory config word wrong");
    a_cfg_write: assert property (
        take && wr_ok |=> cfg == $past(cmd_data_i) && !rsp_refused_o)
        else $error("config write not applied");
    a_boot_len: assert property (
        state_r == pfcs_pkg::PFCS_ST_STRAP && ce_i ##1 s_boot_run |-> !boot_done_o ##1 boot_done_o)
        else $error("boot load length wrong");
    a_store_seq: assert property (
        ce_i throughout (s_store_taken ##1 s_store_run) |=> user_valid && cmd_ready_o)
        else $error("store did not commit user set");
    a_store_def: assert property (
        take && is_store_def |=> rsp_refused_o ##0 state_r == pfcs_pkg::PFCS_ST_IDLE)
        else $error("store default not refused");
    a_no_pec: assert property (
        take && cmd_send_byte_i && !cmd_pec_ok_i |=> rsp_refused_o && cmd_ready_o)
        else $error("send byte without PEC acted on");
    a_read_back: assert property (
        take && is_cfg_rd |=> rsp_valid_o && rsp_data_o == $past(cfg))
        else $error("config read mismatch");
    a_rsp_taken: assert property (
        take |=> rsp_valid_o)
        else $error("taken request not answered");
    a_rsp_quiet: assert property (
        ce_i && !take |=> !rsp_valid_o)
        else $error("answer without request");
    a_store_busy: assert property (
        s_store_taken |=> !cmd_ready_o)
        else $error("ready during store");
    a_rsp_hold: assert property (
        ce_i && !take |=> $stable(rsp_refused_o) && $stable(rsp_data_o))
        else $error("answer fields changed while idle");
    a_strap_pick: assert property (
        state_r == pfcs_pkg::PFCS_ST_STRAP && ce_i
            |=> loadshare_r == $past(droop_load_share_variant_i))
        else $error("variant strap not caught");
    a_bus_source: assert property (
        !cfg[0] |-> unit_on_o == bus_on_i)
        else $error("bus on/off source not followed");
    a_highz_drive: assert property (
        cfg[2] && cfg[5]
            |-> output_good_indicator_o && output_good_indicator_oe_o == !power_good_i)
        else $error("high impedance indicator wrong");
    a_good_off: assert property (
        !cfg[2] |-> !output_good_indicator_oe_o && output_good_indicator_o)
        else $error("disabled indicator driven");
    a_no_pull_bus: assert property (
        !cfg[0] |-> !remote_pull_up_en_o && !remote_pull_down_en_o)
        else $error("remote pull enabled under bus control");
    a_track_clear: assert property (
        boot_done_o && !user_loaded_r |-> !cfg[4] && !cfg[3])
        else $error("unavailable function bit set");
    a_def_kept: assert property (
        take && is_store_def |=> $stable(user_valid))
        else $error("store default touched user area");
    a_other_code: assert property (
        take && !is_store_user && !is_cfg_rd && !is_cfg_wr |=> rsp_refused_o && $stable(cfg))
        else $error("unknown command acted on");
    a_user_boot: assert property (
        state_r == pfcs_pkg::PFCS_ST_STRAP && ce_i && user_valid |=> user_set_loaded_o)
        else $error("user set not chosen at boot");
    a_factory_empty: assert property (
        state_r == pfcs_pkg::PFCS_ST_STRAP && ce_i && !user_valid |=> !user_set_loaded_o)
        else $error("empty user area chosen at boot");
    a_read_zero: assert property (
        take && !is_cfg_rd |=> rsp_data_o == 8'h00)
        else $error("read data on non-read answer");
    a_cfg_hold: assert property (
        ce_i && boot_done_o && !(take && wr_ok) |=> $stable(cfg))
        else $error("config word changed without write");
endmodule

/* verif/pfcs_host_model.sv */
// host model driving the decoded command port
`timescale 1ns/1ps
`include "pfcs_cfg.svh"
module pfcs_host_model #(
    parameter int STORE_WAIT_CYC = 100000
) (
    input wire logic clk_i,
    input wire logic cmd_ready_i,
    input wire logic rsp_valid_i,
    input wire logic rsp_refused_i,
    input wire logic [7:0] rsp_data_i,
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic cmd_send_byte_o,
    output logic cmd_pec_ok_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] cmd_data_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_send_byte_o = 1'b0;
        cmd_pec_ok_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_data_o = 8'h00;
    end

    // one byte transfer, held until taken, answer caught after
    task automatic xfer(input logic wr, input logic sb, input logic pec, input logic [7:0] code,
        input logic [7:0] data, output logic refused, output logic [7:0] rdata, output bit ok);
        int n;
        ok = 1'b0;
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_write_o = wr;
        cmd_send_byte_o = sb;
        cmd_pec_ok_o = pec;
        cmd_code_o = code;
        cmd_data_o = data;
        n = 0;
        while (cmd_ready_i !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        if (cmd_ready_i !== 1'b1) return;
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        cmd_code_o = ~code;
        cmd_data_o = ~data;
        n = 0;
        while (rsp_valid_i !== 1'b1 && n < 4) begin
            @(negedge clk_i);
            n++;
        end
        if (rsp_valid_i !== 1'b1) return;
        refused = rsp_refused_i;
        rdata = rsp_data_i;
        ok = 1'b1;
        if (sb && code == `PFCS_CMD_STORE_USER && !refused) begin
            repeat (STORE_WAIT_CYC) @(negedge clk_i);
        end
    endtask
endmodule

/* verif/pfcs_top_bench.sv */
// self-checking bench of the configuration store
`timescale 1ns/1ps
`include "pfcs_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module pfcs_top_bench;
    logic clk, rst_n, ce, erase_n, ls, bus_on, pin, ah, pg;
    logic vld, wr, sb, pec, ready, rvld, rref, src, pu, pd, on, go, goe, bdone, uload;
    logic [7:0] code, data, rdat, cfg;
    int bad_count = 0;
    int tests_run = 0;
    logic [7:0] sa_codes [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h24, 8'h25};
    logic [7:0] ls_codes [6] = '{8'h82, 8'h83, 8'h86, 8'h87, 8'hA6, 8'hA7};
    logic [7:0] bad_codes [6] = '{8'h83, 8'h82, 8'h0C, 8'h14, 8'h20, 8'h45};

    pfcs_top dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .flash_erase_n_i(erase_n),
        .droop_load_share_variant_i(ls), .cmd_valid_i(vld), .cmd_write_i(wr),
        .cmd_send_byte_i(sb), .cmd_pec_ok_i(pec), .cmd_code_i(code), .cmd_data_i(data),
        .cmd_ready_o(ready), .rsp_valid_o(rvld), .rsp_refused_o(rref), .rsp_data_o(rdat),
        .bus_on_i(bus_on), .remote_pin_i(pin), .remote_active_high_i(ah), .power_good_i(pg),
        .unit_on_o(on), .secondary_remote_on_off_source_o(src), .remote_pull_up_en_o(pu),
        .remote_pull_down_en_o(pd), .output_good_indicator_o(go),
        .output_good_indicator_oe_o(goe), .multi_pin_function_config_o(cfg),
        .boot_done_o(bdone), .user_set_loaded_o(uload));

    pfcs_host_model #(.STORE_WAIT_CYC(200)) host (.clk_i(clk), .cmd_ready_i(ready),
        .rsp_valid_i(rvld), .rsp_refused_i(rref), .rsp_data_i(rdat), .cmd_valid_o(vld),
        .cmd_write_o(wr), .cmd_send_byte_o(sb), .cmd_pec_ok_o(pec), .cmd_code_o(code),
        .cmd_data_o(data));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic test_done();
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
        test_done();
    endtask

    // power cycle with strap and optional flash erase
    task automatic boot(input logic v, input logic erase);
        int n;
        @(negedge clk);
        rst_n = 1'b0;
        erase_n = !erase;
        ls = v;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        erase_n = 1'b1;
        n = 0;
        while (bdone !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (bdone !== 1'b1) hang();
    endtask

    task automatic op(input logic w, input logic s, input logic p, input logic [7:0] c,
        input logic [7:0] d, input logic xref, input logic [7:0] xrd);
        logic r;
        logic [7:0] q;
        bit ok;
        host.xfer(w, s, p, c, d, r, q, ok);
        if (!ok) hang();
        `CHK(r, xref)
        if (!w && !s) `CHK(q, xrd)
    endtask

    function automatic logic [5:0] exp_pins(input logic [7:0] c, input logic [3:0] i);
        logic a, e;
        a = i[3];
        e = !c[2] ? 1'b0 : (c[5] ? !i[0] : 1'b1);
        return {c[0] ? (i[2] == a) : i[1], c[0], c[0] & !a, c[0] & a,
            (c[2] && !c[5]) ? !i[0] : 1'b1, e};
    endfunction

    // every level of active level, pin, bus on/off and good flag
    task automatic chk_pins(input logic [7:0] c);
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            {ah, pin, bus_on, pg} = 4'(i);
            #5;
            `CHK({on, src, pu, pd, go, goe}, exp_pins(c, 4'(i)))
        end
    endtask

    initial begin
        {rst_n, erase_n, ls, bus_on, pin, ah, pg} = 7'h00;
        ce = 1'b1;
        boot(1'b0, 1'b1);
        `CHK(uload, 1'b0)
        `CHK(cfg, `PFCS_CFG_DEF_STANDALONE)
        op(0, 0, 0, `PFCS_CMD_MULTI_PIN_CFG, 8'h00, 0, 8'h04);
        foreach (sa_codes[k]) begin
            op(1, 0, 0, `PFCS_CMD_MULTI_PIN_CFG, sa_codes[k], 0, 8'h00);
            `CHK(cfg, sa_codes[k])
            op(0, 0, 0, `PFCS_CMD_MULTI_PIN_CFG, 8'h00, 0, sa_codes[k]);
            chk_pins(sa_codes[k]);
        end
        foreach (bad_codes[k]) begin
            op(1, 0, 0, `PFCS_CMD_MULTI_PIN_CFG, bad_codes[k], 1, 8'h00);
        end
        `CHK(cfg, 8'h25)
        op(0, 0, 0, 8'h20, 8'h00, 1, 8'h00);
        op(0, 1, 1, `PFCS_CMD_STORE_DEFAULT, 8'h00, 1, 8'h00);
        op(0, 1, 0, `PFCS_CMD_STORE_USER, 8'h00, 1, 8'h00);
        op(0, 1, 1, `PFCS_CMD_STORE_USER, 8'h00, 0, 8'h00);
        op(1, 0, 0, `PFCS_CMD_MULTI_PIN_CFG, 8'h00, 0, 8'h00);
        boot(1'b0, 1'b0);
        `CHK(uload, 1'b1)
        `CHK(cfg, 8'h25)
        boot(1'b1, 1'b1);
        `CHK(cfg, `PFCS_CFG_DEF_LOADSHARE)
        `CHK(uload, 1'b0)
        foreach (ls_codes[k]) begin
            op(1, 0, 0, `PFCS_CMD_MULTI_PIN_CFG, ls_codes[k], 0, 8'h00);
            `CHK(cfg, ls_codes[k])
            chk_pins(ls_codes[k]);
        end
        op(1, 0, 0, `PFCS_CMD_MULTI_PIN_CFG, 8'h05, 1, 8'h00);
        test_done();
    end
endmodule
